// ==== rtl/nsx_pkg.sv ====
package nsx_pkg;

  // ----------------------------------------------------------------
  // Operation codes from the decoder
  // ----------------------------------------------------------------
  localparam logic [2:0] OP_NONE      = 3'h0;
  localparam logic [2:0] OP_SWAP      = 3'h1;
  localparam logic [2:0] OP_XOR_LIT   = 3'h2;
  localparam logic [2:0] OP_XOR_FILE  = 3'h3;
  localparam logic [2:0] OP_DIR_LOAD  = 3'h4;

  // ----------------------------------------------------------------
  // Field positions, selectors and reset values
  // ----------------------------------------------------------------
  localparam int          LO_NIB_LSB  = 0;
  localparam int          HI_NIB_LSB  = 4;
  localparam int          NIB_W       = 4;
  localparam logic        DEST_ACC    = 1'h0;
  localparam logic [6:0]  SEL_PORT_A  = 7'h05;
  localparam logic [6:0]  SEL_PORT_B  = 7'h06;
  localparam logic [6:0]  SEL_PORT_C  = 7'h07;
  localparam logic [7:0]  ACC_RST     = 8'h00;
  localparam logic [7:0]  DIR_RST     = 8'hff;
  localparam logic        ZERO_RST    = 1'h0;
  localparam logic [7:0]  ZERO_BYTE   = 8'h00;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic [2:0] op;
    logic       dest;
    logic [6:0] faddr;
    logic [7:0] literal;
    logic [7:0] fdata;
  } nsx_req_s;

  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] data;
  } nsx_fwr_s;

endpackage

// ==== rtl/nsx_datapath.sv ====
`timescale 1ns/100ps

module nsx_datapath (
  // Clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              rst_b_in,
  // Decoded request
  input  wire nsx_pkg::nsx_req_s req_in,
  // File register write back
  output nsx_pkg::nsx_fwr_s      fwr_out,
  // Core state
  output logic [7:0]             acc_out,
  output logic                   zero_flag_out,
  // Port direction registers
  output logic [7:0]             port_a_direction_reg_out,
  output logic [7:0]             port_b_direction_reg_out,
  output logic [7:0]             port_c_direction_reg_out
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic dest_is_file(input nsx_pkg::nsx_req_s r);
    dest_is_file = (r.dest != nsx_pkg::DEST_ACC);
  endfunction

  function automatic logic dir_hit(input logic load, input logic [6:0] faddr,
                                   input logic [6:0] sel);
    dir_hit = load && (faddr == sel);
  endfunction

  function automatic logic [7:0] nib_swap(input logic [7:0] v);
    nib_swap = {v[nsx_pkg::LO_NIB_LSB +: nsx_pkg::NIB_W],
                v[nsx_pkg::HI_NIB_LSB +: nsx_pkg::NIB_W]};
  endfunction

  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == nsx_pkg::ZERO_BYTE);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]        acc;
  logic              zero_flag;
  logic [7:0]        dir_a;
  logic [7:0]        dir_b;
  logic [7:0]        dir_c;
  nsx_pkg::nsx_fwr_s fwr;
  logic [7:0]        next_acc;
  logic              next_zero_flag;
  logic [7:0]        next_dir_a;
  logic [7:0]        next_dir_b;
  logic [7:0]        next_dir_c;
  nsx_pkg::nsx_fwr_s next_fwr;

  // ----------------------------------------------------------------
  // Operand decode
  // ----------------------------------------------------------------
  logic              do_swap;
  logic              do_xor_lit;
  logic              do_xor_file;
  logic              do_dir_load;
  logic              to_file;
  logic [7:0]        xor_operand;
  logic [7:0]        swapped;
  logic [7:0]        xored;

  // Only a valid request raises a strobe; unknown codes raise none and change nothing but the write-back address.
  always_comb begin
    do_swap     = 1'h0;
    do_xor_lit  = 1'h0;
    do_xor_file = 1'h0;
    do_dir_load = 1'h0;
    if (req_in.valid) begin
      case (req_in.op)
        nsx_pkg::OP_SWAP: begin
          do_swap = 1'h1;
        end
        nsx_pkg::OP_XOR_LIT: begin
          do_xor_lit = 1'h1;
        end
        nsx_pkg::OP_XOR_FILE: begin
          do_xor_file = 1'h1;
        end
        nsx_pkg::OP_DIR_LOAD: begin
          do_dir_load = 1'h1;
        end
        default: begin
        end
      endcase
    end
    to_file     = dest_is_file(req_in);
    xor_operand = do_xor_lit ? req_in.literal : req_in.fdata;
    swapped     = nib_swap(req_in.fdata);
    xored       = acc ^ xor_operand;
  end

  // ----------------------------------------------------------------
  // Accumulator and zero flag
  // ----------------------------------------------------------------
  // Each XOR and direction load reads the accumulator as it stood before its own edge,
  // so requests may follow each other on every cycle.
  always_comb begin
    next_acc       = acc;
    next_zero_flag = zero_flag;
    // Swap and direction load never touch the flag.
    if (do_swap && !to_file) begin
      next_acc = swapped;
    end
    if (do_xor_lit) begin
      next_acc       = xored;
      next_zero_flag = is_zero(xored);
    end
    if (do_xor_file) begin
      next_zero_flag = is_zero(xored);
      if (!to_file) begin
        next_acc = xored;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      acc       <= nsx_pkg::ACC_RST;
      zero_flag <= nsx_pkg::ZERO_RST;
    end else begin
      acc       <= next_acc;
      zero_flag <= next_zero_flag;
    end
  end

  // ----------------------------------------------------------------
  // Direction registers
  // ----------------------------------------------------------------
  // A selector outside the three ports is refused and leaves every register but the write-back address alone.
  always_comb begin
    next_dir_a = dir_a;
    if (dir_hit(do_dir_load, req_in.faddr, nsx_pkg::SEL_PORT_A)) begin
      next_dir_a = acc;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dir_a <= nsx_pkg::DIR_RST;
    end else begin
      dir_a <= next_dir_a;
    end
  end

  always_comb begin
    next_dir_b = dir_b;
    if (dir_hit(do_dir_load, req_in.faddr, nsx_pkg::SEL_PORT_B)) begin
      next_dir_b = acc;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dir_b <= nsx_pkg::DIR_RST;
    end else begin
      dir_b <= next_dir_b;
    end
  end

  always_comb begin
    next_dir_c = dir_c;
    if (dir_hit(do_dir_load, req_in.faddr, nsx_pkg::SEL_PORT_C)) begin
      next_dir_c = acc;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dir_c <= nsx_pkg::DIR_RST;
    end else begin
      dir_c <= next_dir_c;
    end
  end

  // ----------------------------------------------------------------
  // File write back
  // ----------------------------------------------------------------
  // The address follows the request on every cycle; only the strobe marks a write,
  // and the data holds its last written value between writes.
  always_comb begin
    next_fwr.we   = 1'h0;
    next_fwr.addr = req_in.faddr;
    next_fwr.data = fwr.data;
    if (do_swap && to_file) begin
      next_fwr.we   = 1'h1;
      next_fwr.data = swapped;
    end
    if (do_xor_file && to_file) begin
      next_fwr.we   = 1'h1;
      next_fwr.data = xored;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fwr <= '0;
    end else begin
      fwr <= next_fwr;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output leaves a flop directly, with no logic after it.
  assign acc_out                  = acc;
  assign zero_flag_out            = zero_flag;
  assign port_a_direction_reg_out = dir_a;
  assign port_b_direction_reg_out = dir_b;
  assign port_c_direction_reg_out = dir_c;
  assign fwr_out                  = fwr;

endmodule

// ==== verif/nsx_sva.sv ====
`timescale 1ns/100ps
module nsx_sva (
  // Watched ports.
  input wire logic              clk_sys_in,
  input wire logic              rst_b_in,
  input wire nsx_pkg::nsx_req_s req_in,
  input wire nsx_pkg::nsx_fwr_s fwr_out,
  input wire logic [7:0]        acc_out,
  input wire logic              zero_flag_out,
  input wire logic [7:0]        port_a_direction_reg_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_op(logic [2:0] o); req_in.valid && req_in.op == o; endsequence
  a_swap_acc: assert property (s_op(nsx_pkg::OP_SWAP) ##0 !req_in.dest |=>
    acc_out == {$past(req_in.fdata[3:0]), $past(req_in.fdata[7:4])}) else $error("swap acc");
  a_swap_file: assert property (s_op(nsx_pkg::OP_SWAP) ##0 req_in.dest |=>
    fwr_out.we && fwr_out.addr == $past(req_in.faddr) && $stable(acc_out)) else $error("swap f");
  a_swap_flags: assert property (s_op(nsx_pkg::OP_SWAP) |=>
    $stable(zero_flag_out)) else $error("swap flag");
  a_xlit_acc: assert property (s_op(nsx_pkg::OP_XOR_LIT) |=>
    acc_out == ($past(acc_out) ^ $past(req_in.literal)) && zero_flag_out == (acc_out == 8'h00))
    else $error("xor literal");
  a_xfile_file: assert property (s_op(nsx_pkg::OP_XOR_FILE) ##0 req_in.dest |=>
    fwr_out.data == ($past(acc_out) ^ $past(req_in.fdata)) &&
    zero_flag_out == (fwr_out.data == 8'h00))
    else $error("xor file");
  a_dir_a: assert property (s_op(nsx_pkg::OP_DIR_LOAD) ##0 req_in.faddr == 7'h05 |=>
    port_a_direction_reg_out == $past(acc_out) && $stable(zero_flag_out)) else $error("dir a");
endmodule
bind nsx_datapath nsx_sva u_sva (.clk_sys_in, .rst_b_in, .req_in, .fwr_out, .acc_out,
  .zero_flag_out, .port_a_direction_reg_out);

// ==== verif/nsx_rf_model.sv ====
`timescale 1ns/100ps
module nsx_rf_model (
  // Clock, write back and read port.
  input  wire logic              clk_sys_in,
  input  wire nsx_pkg::nsx_fwr_s fwr_in,
  input  wire logic [6:0]        addr_in,
  output logic [7:0]             data_out
);
  logic [7:0] mem [128];
  // A write still in flight is forwarded so a back-to-back read sees it.
  assign data_out = (fwr_in.we && fwr_in.addr == addr_in) ? fwr_in.data : mem[addr_in];
  always @(posedge clk_sys_in) if (fwr_in.we) mem[fwr_in.addr] <= fwr_in.data;
endmodule

// ==== verif/test_nibble_swap_xor_dir_load_ops.sv ====
`timescale 1ns/100ps
module test_nibble_swap_xor_dir_load_ops;
  logic              clk_sys_in = 1'h0;
  logic              rst_b_in = 1'h0;
  nsx_pkg::nsx_req_s req = '0;
  nsx_pkg::nsx_req_s rq;
  nsx_pkg::nsx_fwr_s fwr;
  logic [7:0]        acc, fd, e_acc = nsx_pkg::ACC_RST, e_fd, sh [128];
  logic [7:0]        e_d [3] = '{nsx_pkg::DIR_RST, nsx_pkg::DIR_RST, nsx_pkg::DIR_RST};
  logic [7:0]        dir [3];
  logic [6:0]        e_fa = 7'h00;
  logic              zero, e_z = nsx_pkg::ZERO_RST, e_we = 1'h0;
  int                errors = 0;
  int                n_checks = 0;
  always_comb rq = {req[27:8], fd};
  nsx_datapath uut (.clk_sys_in, .rst_b_in, .req_in(rq), .fwr_out(fwr), .acc_out(acc),
    .zero_flag_out(zero), .port_a_direction_reg_out(dir[0]),
    .port_b_direction_reg_out(dir[1]), .port_c_direction_reg_out(dir[2]));
  nsx_rf_model rf (.clk_sys_in, .fwr_in(fwr), .addr_in(req.faddr), .data_out(fd));
  initial forever #25 clk_sys_in = ~clk_sys_in;
  function automatic logic [7:0] res(logic [2:0] op, logic [7:0] w, k, f);
    if (op == nsx_pkg::OP_SWAP) return {f[3:0], f[7:4]};
    return w ^ ((op == nsx_pkg::OP_XOR_LIT) ? k : f);
  endfunction
  task automatic cmp(string n, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic step(logic [2:0] op, logic d, logic [6:0] a, logic [7:0] k);
    logic [7:0] r;
    @(posedge clk_sys_in);
    req <= {1'h1, op, d, a, k, 8'h00};
    @(negedge clk_sys_in);
    cmp("acc", e_acc, acc);
    cmp("zero", {7'h0, e_z}, {7'h0, zero});
    for (int i = 0; i < 3; i++) cmp("dir", e_d[i], dir[i]);
    cmp("we", {7'h0, e_we}, {7'h0, fwr.we});
    if (e_we) cmp("fdata", e_fd, fwr.data);
    if (e_we) cmp("faddr", {1'h0, e_fa}, {1'h0, fwr.addr});
    r = res(op, e_acc, k, sh[a]);
    if (op == nsx_pkg::OP_DIR_LOAD && a inside {5, 6, 7}) e_d[a - 5] = e_acc;
    if (op inside {nsx_pkg::OP_XOR_LIT, nsx_pkg::OP_XOR_FILE}) e_z = (r == 8'h00);
    e_we = d && op inside {nsx_pkg::OP_SWAP, nsx_pkg::OP_XOR_FILE};
    if (e_we) begin
      sh[a] = r;
      e_fd  = r;
      e_fa  = a;
    end else if (op inside {nsx_pkg::OP_SWAP, nsx_pkg::OP_XOR_LIT, nsx_pkg::OP_XOR_FILE}) begin
      e_acc = r;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    void'($urandom(3));
    foreach (sh[i]) sh[i] = 8'($urandom);
    foreach (sh[i]) rf.mem[i] = sh[i];
    repeat (6) @(posedge clk_sys_in);
    rst_b_in <= 1'h1;
    step(nsx_pkg::OP_XOR_LIT, 0, 0, 8'h5a);
    step(nsx_pkg::OP_XOR_LIT, 1, 0, 8'h5a);
    for (int s = 3; s < 9; s++) step(3'(s % 5), 1'(s), 7'h10, 8'hc3);
    for (int s = 4; s < 8; s++) step(nsx_pkg::OP_DIR_LOAD, 0, 7'(s), 8'h00);
    $display("corner test done");
    repeat (300) step(3'($urandom_range(7)), 1'($urandom), 7'($urandom_range(7)), 8'($urandom));
    step(nsx_pkg::OP_NONE, 0, 0, 8'h00);
    $display("random test done");
    report_and_stop();
  end
  initial begin
    #40000;
    errors++;
    report_and_stop();
  end
endmodule
